/* File: src/csb_pkg.sv */
package csb_pkg;
  // ***********************************************
  // register map (byte addresses on the bus)
  // ***********************************************
  localparam logic [7:0]  CSB_CS1_START_OFS = 8'h00;
  localparam logic [7:0]  CSB_CS2_START_OFS = 8'h04;
  localparam logic [7:0]  CSB_STATUS_OFS    = 8'h08;

  // ***********************************************
  // field layout and reset values
  // ***********************************************
  localparam int          CSB_HI_MSB        = 15;
  localparam int          CSB_HI_LSB        = 7;
  localparam int          CSB_B11_POS       = 3;
  localparam logic [15:0] CSB_IMPL_MASK     = 16'hff88;
  localparam logic [15:0] CSB_CS1_RESET     = 16'h0080;
  localparam logic [15:0] CSB_CS2_RESET     = 16'h0880;
  localparam logic [23:0] CSB_ADDR_TOP      = 24'hffffff;

  // ***********************************************
  // bus encodings
  // ***********************************************
  localparam logic [1:0]  CSB_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  CSB_HTRANS_SEQ    = 2'h3;

  // register image to 24-bit region start address
  function automatic logic [23:0] csb_start_addr(input logic [15:0] r);
    csb_start_addr = {r[15:7], 3'h0, r[3], 11'h000};
  endfunction : csb_start_addr
endpackage : csb_pkg

/* File: src/csb_region_cmp.sv */
`timescale 1ns/10ps
module csb_region_cmp
  import csb_pkg::*;
(
  input  wire logic [23:0] addr_i,   // current bus address
  input  wire logic [23:0] start_i,  // region start
  input  wire logic [23:0] last_i,   // region last address
  output logic             hit_o     // address inside region
);
  assign hit_o = (addr_i >= start_i) && (addr_i <= last_i);
endmodule : csb_region_cmp

/* File: src/csb_top.sv */
// Contract
// - bits 15..7 hold start address bits 23..15 of the region, read and write.
// - bit 3 holds start address bit 11, giving a finer start boundary.
// - bits 6..4 and 2..0 read as zero and ignore writes.
// - after reset region one start is 0080h and region two start is 0880h.
// - a whole-register write of zero to region two start makes region one end at FFFFFFh.
// - a zero write to region one start only stores zero.
`timescale 1ns/10ps
module csb_top
  import csb_pkg::*;
(
  input  wire logic        clk_i,        // 20 MHz system clock
  input  wire logic        nrst_i,       // async reset, active low
  input  wire logic        hsel_i,       // slave select
  input  wire logic [31:0] haddr_i,      // address
  input  wire logic [1:0]  htrans_i,     // transfer type
  input  wire logic        hwrite_i,     // write not read
  input  wire logic [2:0]  hsize_i,      // transfer size
  input  wire logic        hready_i,     // bus ready
  input  wire logic [31:0] hwdata_i,     // write data
  output logic [31:0]      hrdata_o,     // read data
  output logic             hreadyout_o,  // slave ready
  output logic             hresp_o,      // response, always okay
  input  wire logic [23:0] bus_addr_i,   // current port address
  input  wire logic        bus_active_i, // port cycle in progress
  output logic             cs1_active_o, // region one selected
  output logic             cs2_active_o, // region two selected
  output logic             cs1_extended_o // region one runs to top
);

  // ***********************************************
  // registers
  // ***********************************************
  logic [15:0] chip_select_one_region_start;
  logic [15:0] chip_select_two_region_start;
  logic        extended;
  logic        ph_wr;
  logic        ph_rd;
  logic [7:0]  ph_ofs;
  logic        take;
  logic [15:0] wdat;
  logic [23:0] cs1_start;
  logic [23:0] cs2_start;
  logic [23:0] cs1_last;
  logic        hit1;
  logic        hit2;
  logic [31:0] next_rdata;
  logic [15:0] next_cs1_start;
  logic [15:0] next_cs2_start;
  logic        next_extended;
  logic [2:0]  wr_sel;
  logic [2:0]  rd_sel;
  logic        cs1_open;

  // ***********************************************
  // offset decode
  // ***********************************************
  // one-hot select: bit 0 region one, bit 1 region two, bit 2 status
  function automatic logic [2:0] decode_ofs(input logic [7:0] ofs);
    if (ofs == CSB_CS1_START_OFS) begin
      decode_ofs = 3'h1;
    end else if (ofs == CSB_CS2_START_OFS) begin
      decode_ofs = 3'h2;
    end else if (ofs == CSB_STATUS_OFS) begin
      decode_ofs = 3'h4;
    end else begin
      decode_ofs = 3'h0;
    end
  endfunction : decode_ofs

  assign wr_sel = ph_wr ? decode_ofs(ph_ofs) : 3'h0;
  assign rd_sel = decode_ofs(haddr_i[7:0]);

  assign take = hsel_i && hready_i && (htrans_i == CSB_HTRANS_NONSEQ || htrans_i == CSB_HTRANS_SEQ);
  assign wdat = hwdata_i[15:0] & CSB_IMPL_MASK;

  // ***********************************************
  // bus address phase capture
  // ***********************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_wr  <= 1'b0;
      ph_rd  <= 1'b0;
      ph_ofs <= 8'h00;
    end else begin
      ph_wr  <= take && hwrite_i;
      ph_rd  <= take && !hwrite_i;
      ph_ofs <= haddr_i[7:0];
    end
  end

  // zero-wait slave: every data phase completes in one cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // ***********************************************
  // region start registers
  // ***********************************************
  // write data lands at the end of the data phase
  always_comb begin
    next_cs1_start = chip_select_one_region_start;
    next_cs2_start = chip_select_two_region_start;
    next_extended  = extended;
    if (wr_sel[0]) begin
      next_cs1_start = wdat;
    end
    if (wr_sel[1]) begin
      next_cs2_start = wdat;
      // unimplemented bits count too: only a write of all zeros arms it
      next_extended  = (hwdata_i[15:0] == 16'h0000);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chip_select_one_region_start <= CSB_CS1_RESET;
    end else begin
      chip_select_one_region_start <= next_cs1_start;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chip_select_two_region_start <= CSB_CS2_RESET;
    end else begin
      chip_select_two_region_start <= next_cs2_start;
    end
  end

  // ***********************************************
  // extension flag
  // ***********************************************
  // a zero write to region one has no such effect
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      extended <= 1'b0;
    end else begin
      extended <= next_extended;
    end
  end

  // read data registered at the address phase so hrdata is a flop;
  // next values forward a write still in its data phase
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_sel[0]) begin
      next_rdata = {16'h0000, next_cs1_start};
    end else if (rd_sel[1]) begin
      next_rdata = {16'h0000, next_cs2_start};
    end else if (rd_sel[2]) begin
      next_rdata = {29'h0, next_extended, cs2_active_o, cs1_active_o};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (take && !hwrite_i) begin
      hrdata_o <= next_rdata;
    end
  end

  // ***********************************************
  // region decode
  // ***********************************************
  assign cs1_start = csb_start_addr(chip_select_one_region_start);
  assign cs2_start = csb_start_addr(chip_select_two_region_start);
  // below region two start; runs to top when extended
  assign cs1_last  = extended ? CSB_ADDR_TOP : (cs2_start - 24'h000001);
  // region one is empty when region two starts at zero without the extension
  assign cs1_open  = extended || (cs2_start != 24'h000000);

  csb_region_cmp u_cmp1 (
    .addr_i  (bus_addr_i),
    .start_i (cs1_start),
    .last_i  (cs1_last),
    .hit_o   (hit1)
  );

  csb_region_cmp u_cmp2 (
    .addr_i  (bus_addr_i),
    .start_i (cs2_start),
    .last_i  (CSB_ADDR_TOP),
    .hit_o   (hit2)
  );

  // ***********************************************
  // chip select outputs
  // ***********************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs1_active_o <= 1'b0;
    end else begin
      cs1_active_o <= bus_active_i && hit1 && cs1_open;
    end
  end

  // chip select two is never driven while extended
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs2_active_o <= 1'b0;
    end else begin
      cs2_active_o <= bus_active_i && hit2 && !extended;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs1_extended_o <= 1'b0;
    end else begin
      cs1_extended_o <= extended;
    end
  end
endmodule : csb_top

/* File: test/csb_props.sv */
`timescale 1ns/10ps
module csb_props
  import csb_pkg::*;
(
  input wire logic        clk_i,          // clock
  input wire logic        nrst_i,         // reset
  input wire logic        hsel_i,         // select
  input wire logic [31:0] haddr_i,        // address
  input wire logic [1:0]  htrans_i,       // type
  input wire logic        hwrite_i,       // write
  input wire logic        hready_i,       // ready
  input wire logic [31:0] hwdata_i,       // wdata
  input wire logic [31:0] hrdata_o,       // rdata
  input wire logic        bus_active_i,   // port busy
  input wire logic        cs1_active_o,   // region one
  input wire logic        cs2_active_o,   // region two
  input wire logic        cs1_extended_o  // extended
);
  logic       rd_ph;
  logic       wr_ph;
  logic [7:0] wa;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_ph <= 1'b0;
      wr_ph <= 1'b0;
    end else if (hready_i) begin
      rd_ph <= hsel_i && htrans_i[1] && !hwrite_i;
      wr_ph <= hsel_i && htrans_i[1] && hwrite_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (hready_i) begin
      wa <= haddr_i[7:0];
    end
  end
  a_rsvd_zero:   assert property (rd_ph && (wa == CSB_CS1_START_OFS || wa == CSB_CS2_START_OFS)
                   |-> (hrdata_o & ~32'h0000ff88) == 32'h0) else $error("gap bits");
  a_ext_arm:     assert property (wr_ph && wa == CSB_CS2_START_OFS && hwdata_i[15:0] == 16'h0
                   |-> ##[1:2] cs1_extended_o) else $error("no extension");
  a_ext_no_cs2:  assert property (cs1_extended_o |-> !cs2_active_o) else $error("cs2 while extended");
  a_cs1_zero:    assert property (wr_ph && wa == CSB_CS1_START_OFS |=> $stable(cs1_extended_o))
                   else $error("cs1 write moved extension");
  a_one_region:  assert property (!(cs1_active_o && cs2_active_o)) else $error("both regions");
  a_idle_quiet:  assert property (!bus_active_i |=> !cs1_active_o && !cs2_active_o) else $error("idle select");
  a_reset_clear: assert property ($rose(nrst_i) |-> !cs1_extended_o) else $error("extended at reset");
endmodule : csb_props

bind csb_top csb_props u_props (.*);

/* File: test/csb_port_model.sv */
`timescale 1ns/10ps
module csb_port_model (
  input  wire logic        clk_i,        // clock
  input  wire logic        go_i,         // start cycle
  input  wire logic [23:0] addr_i,       // cycle address
  output logic [23:0]      bus_addr_o,   // port address
  output logic             bus_active_o  // cycle active
);
  // released address toggles so a stale value never looks valid
  always @(posedge clk_i) begin
    bus_active_o <= go_i;
    bus_addr_o   <= go_i ? addr_i : ~bus_addr_o;
  end
endmodule : csb_port_model

/* File: test/csb_top_tb.sv */
`timescale 1ns/10ps
module csb_top_tb;
  logic        clk_i = 0, nrst_i = 0, hwrite_i = 0, go = 0, hsel_i = 1;
  logic [1:0]  htrans_i = 0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd;
  logic [23:0] paddr = 0, bus_addr_i;
  logic        hreadyout_o, hresp_o, bus_active_i, cs1_active_o, cs2_active_o, cs1_extended_o;
  wire logic   hready_i = hreadyout_o;
  int          num_errors = 0, checked = 0, cyc = 0;
  always #25 clk_i = ~clk_i;
  csb_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
               .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hready_i), .hwdata_i(hwdata_i),
               .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .bus_addr_i(bus_addr_i),
               .bus_active_i(bus_active_i), .cs1_active_o(cs1_active_o), .cs2_active_o(cs2_active_o),
               .cs1_extended_o(cs1_extended_o));
  csb_port_model PM (.clk_i(clk_i), .go_i(go), .addr_i(paddr), .bus_addr_o(bus_addr_i), .bus_active_o(bus_active_i));
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    chk(hresp_o, 32'h0);
  endtask : bus
  task probe(input logic [23:0] a, input logic c1, input logic c2);
    @(posedge clk_i);
    go    <= 1'b1;
    paddr <= a;
    repeat (3) @(posedge clk_i);
    chk({cs1_active_o, cs2_active_o}, {c1, c2});
    go <= 1'b0;
  endtask : probe
  task t_fields;
    bus(0, 8'h00, 0); chk(rd, 32'h0080);
    bus(0, 8'h04, 0); chk(rd, 32'h0880);
    bus(0, 8'h0c, 0); chk(rd, 32'h0);
    bus(1, 8'h00, 32'hffffffff); bus(0, 8'h00, 0); chk(rd, 32'hff88);
    bus(1, 8'h00, 32'h0); probe(24'h000000, 1, 0); chk(cs1_extended_o, 0);
    $display("fields test done");
  endtask : t_fields
  task t_ranges;
    bus(1, 8'h00, 32'h0080); bus(1, 8'h04, 32'h0888);
    probe(24'h007fff, 0, 0); probe(24'h008000, 1, 0);
    probe(24'h0887ff, 1, 0); probe(24'h088800, 0, 1);
    $display("ranges test done");
  endtask : t_ranges
  task t_extend;
    bus(1, 8'h04, 32'h0); bus(0, 8'h08, 0); chk(rd, 32'h4);
    probe(24'hffffff, 1, 0); chk(cs1_extended_o, 1);
    // a nonzero region two write ends the extension and cs2 takes the top back
    bus(1, 8'h04, 32'h0880); probe(24'hffffff, 0, 1);
    $display("extend test done");
  endtask : t_extend
  task t_reset;
    bus(1, 8'h04, 32'h0); bus(1, 8'h00, 32'h1234);
    @(posedge clk_i);
    chk(cs1_extended_o, 1);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({hreadyout_o, cs1_extended_o, cs1_active_o, cs2_active_o}, 0);
    nrst_i <= 1'b1;
    bus(0, 8'h00, 0); chk(rd, 32'h0080);
    bus(0, 8'h04, 0); chk(rd, 32'h0880);
    $display("reset test done");
  endtask : t_reset
  task wrap_up;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      wrap_up;
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_fields;
    t_ranges;
    t_extend;
    t_reset;
    wrap_up;
  end
endmodule : csb_top_tb
